// ---- inc/pfa_pkg.sv ----
// Purpose: Shared constants and types for the program flow and address unit
// Assumes: Single clock, synchronous active-high reset
// Notes:   Register selector codes are local to this block
package pfa_pkg;
	localparam int PAW = 24;
	localparam int DAW = 23;
	localparam int DW  = 16;
	localparam logic [PAW-1:0] PC_RESET    = 24'h00_0000;
	localparam logic [PAW-1:0] FETCH_STEP  = 24'h00_0004;
	localparam logic [DW-1:0]  REG_RESET   = 16'h0000;
	localparam logic [7:0]     IRQ_VECTOR_STRIDE = 8'h08;
	localparam logic [PAW-1:0] IRQ_BASE    = 24'hFF_FF00;

	// Register selectors for the plain register port
	localparam logic [5:0] SEL_BLC0  = 6'h00;
	localparam logic [5:0] SEL_BLC1  = 6'h01;
	localparam logic [5:0] SEL_BLS1  = 6'h02;
	localparam logic [5:0] SEL_BSA0  = 6'h03;
	localparam logic [5:0] SEL_BSA1  = 6'h04;
	localparam logic [5:0] SEL_BEA0  = 6'h05;
	localparam logic [5:0] SEL_BEA1  = 6'h06;
	localparam logic [5:0] SEL_SLC   = 6'h07;
	localparam logic [5:0] SEL_CSLC  = 6'h08;
	localparam logic [5:0] SEL_IER0  = 6'h09;
	localparam logic [5:0] SEL_IER1  = 6'h0A;
	localparam logic [5:0] SEL_DIER0 = 6'h0B;
	localparam logic [5:0] SEL_DIER1 = 6'h0C;
	localparam logic [5:0] SEL_ST0   = 6'h0D;
	localparam logic [5:0] SEL_ST3   = 6'h10;
	localparam logic [5:0] SEL_AREG0 = 6'h20;
	localparam logic [5:0] SEL_AREGN = 6'h3F;
	localparam int NAREG = 32;

	typedef enum logic [3:0] {
		ALU_ADD = 4'h0, ALU_SUB = 4'h1, ALU_CMP = 4'h2, ALU_AND = 4'h3,
		ALU_OR  = 4'h4, ALU_XOR = 4'h5, ALU_SRA = 4'h6, ALU_SRL = 4'h7,
		ALU_SHL = 4'h8, ALU_ABS = 4'h9, ALU_BTST = 4'hA, ALU_BSET = 4'hB,
		ALU_BCLR = 4'hC, ALU_BNOT = 4'hD, ALU_ROL = 4'hE, ALU_MOV = 4'hF
	} pfa_alu_op_t;

	typedef enum logic [3:0] {
		FL_SEQ    = 4'b0001,
		FL_SINGLE = 4'b0010,
		FL_BLOCK  = 4'b0100,
		FL_IRQ    = 4'b1000
	} pfa_flow_t;
endpackage

// ---- logic/pfa_core.sv ----
// Purpose: Program flow unit and address-data flow unit of a DSP CPU
// Assumes: Decoder, data unit and memory interface are on ref_clk
// Notes:   Single-cycle ALU; one data address generated per cycle
//
// Implementation choices: the placing of the registers and the strobed register port.

// Notes on behaviour
// - Program fetch addresses are 24-bit byte addresses.
// - Fetch steps sequentially unless branching to an immediate or register value.
// - Every fetch address goes out on the program read address bus.
// - Conditions are evaluated from unit test flags and steer the address generator.
// - Interrupt servicing starts only for a requested and enabled interrupt.
// - Single-repeat repeats next instruction; block-repeat repeats the following block.
// - Three loop levels: block in block, single repeat inside either.
// - Every repeat loop can be interrupted.
// - Control instructions run alongside a parallel data instruction.
// - The program counter cannot be read or written by instructions.
// - Return address and context move only together as a double word.
// - Other flow registers load immediates and exchange with other units.
// - Two block counters, inner count save, start and end address per level.
// - Two irq enable, two debug irq enable and four status registers.
// - Data generator makes all data and I/O addresses from immediates and registers.
// - Flow unit selects linear or circular indirect addressing; generator obeys.
// - 16-bit ALU: add, sub, compare, logic, shifts, absolute value.
// - ALU tests, sets, clears and complements single bits.
// - ALU modifies, moves, rotates and takes shifter results into registers.
// - Address registers connect both ways with generator and ALU.
// - Circular addressing uses dedicated size and base registers.
// - Data addresses are 23-bit word addresses.
module pfa_core
	import pfa_pkg::*;
(
	// Clock and reset
	input  wire logic              ref_clk,
	input  wire logic              sys_rst,
	// Decoder commands
	input  wire logic              dec_valid,
	input  wire logic              dec_branch,
	input  wire logic              dec_branch_reg,
	input  wire logic              dec_cond,
	input  wire logic [3:0]        dec_cond_sel,
	input  wire logic [PAW-1:0]    dec_imm_addr,
	input  wire logic              dec_rpt_single,
	input  wire logic              dec_rpt_block,
	input  wire logic              dec_rpt_level,
	input  wire logic [DW-1:0]     dec_rpt_count,
	input  wire logic [PAW-1:0]    dec_blk_end,
	input  wire logic              dec_data_par,
	// Fetch side
	input  wire logic              fetch_ready,
	input  wire logic [PAW-1:0]    dcu_reg_addr,
	input  wire logic [7:0]        test_flags,
	// Interrupts
	input  wire logic [31:0]       irq_req,
	input  wire logic [31:0]       dbg_irq_req,
	input  wire logic              irq_resume,
	// Context double-word move
	input  wire logic              ctx_wr,
	input  wire logic [31:0]       ctx_wdata,
	// Register port
	input  wire logic [5:0]        reg_addr,
	input  wire logic [DW-1:0]     reg_wdata,
	input  wire logic              reg_wr,
	input  wire logic              reg_rd,
	// Address ALU
	input  wire logic              alu_go,
	input  wire pfa_alu_op_t       alu_op,
	input  wire logic [4:0]        alu_dst,
	input  wire logic [4:0]        alu_src,
	input  wire logic [DW-1:0]     alu_imm,
	input  wire logic              alu_use_imm,
	input  wire logic              alu_shifter,
	input  wire logic [DW-1:0]     shifter_val,
	// Data address generation
	input  wire logic              dag_go,
	input  wire logic              dag_indirect,
	input  wire logic              dag_circ_req,
	input  wire logic [2:0]        dag_ptr,
	input  wire logic [DW-1:0]     dag_step,
	input  wire logic [DAW-1:0]    dag_imm,
	input  wire logic              dag_write,
	// Outputs
	output logic [PAW-1:0]         program_read_address_bus,
	output logic                   prog_fetch_en,
	output logic [DAW-1:0]         data_addr,
	output logic                   data_rd_en,
	output logic                   data_wr_en,
	output logic [DW-1:0]          reg_rdata,
	output logic [31:0]            ctx_rdata,
	output logic                   irq_taken,
	output logic                   alu_test_bit,
	output logic                   loop_active,
	output logic                   par_issue
);
	pfa_flow_t       flow;
	logic [PAW-1:0]  program_counter;
	logic [PAW-1:0]  next_pc;
	logic [23:0]     return_address_reg;
	logic [7:0]      control_flow_context;
	logic [DW-1:0]   block_loop_counters [2];
	logic [DW-1:0]   inner_loop_count_save;
	logic [PAW-1:0]  block_loop_start_addrs [2];
	logic [PAW-1:0]  block_loop_end_addrs [2];
	logic [DW-1:0]   single_loop_counter;
	logic [DW-1:0]   computed_single_loop_count;
	logic [DW-1:0]   irq_enable_regs [2];
	logic [DW-1:0]   debug_irq_enable_regs [2];
	logic [DW-1:0]   cpu_status_regs [4];
	logic [DW-1:0]   areg [NAREG];
	logic [1:0]      blk_on;
	logic            cond_true;
	logic            irq_hit;
	logic [4:0]      irq_num;

	// Index 0-7 pointers, 8-11 ring size, 12-15 ring base, 16-19 temps, 20-23 pages
	function automatic logic [4:0] ring_size_idx(input logic [2:0] p);
		return 5'd8 + {3'd0, p[2:1]};
	endfunction
	function automatic logic [4:0] ring_base_idx(input logic [2:0] p);
		return 5'd12 + {3'd0, p[2:1]};
	endfunction

	// Interrupt gating: enabled request only, global enable in status 1 bit 0
	always_comb begin
		logic [31:0] pend;
		pend    = (irq_req & {irq_enable_regs[1], irq_enable_regs[0]})
			| (dbg_irq_req & {debug_irq_enable_regs[1], debug_irq_enable_regs[0]});
		irq_hit = 1'b0;
		irq_num = 5'd0;
		for (int i = 31; i >= 0; i--) begin
			if (pend[i] && cpu_status_regs[1][0]) begin
				irq_hit = 1'b1;
				irq_num = 5'(i);
			end
		end
	end

	assign cond_true = test_flags[dec_cond_sel[2:0]] ^ dec_cond_sel[3];

	// Fetch address selection, loop wrap and interrupt entry
	always_comb begin
		next_pc = program_counter + FETCH_STEP;
		if (irq_hit) begin
			next_pc = IRQ_BASE + PAW'({irq_num, 3'd0});
		end else if (dec_valid && dec_branch && (!dec_cond || cond_true)) begin
			next_pc = dec_branch_reg ? dcu_reg_addr : dec_imm_addr;
		end else if (flow == FL_SINGLE && single_loop_counter != REG_RESET) begin
			next_pc = program_counter;
		end else if (blk_on[1] && program_counter >= block_loop_end_addrs[1]
			&& block_loop_counters[1] != REG_RESET) begin
			next_pc = block_loop_start_addrs[1];
		end else if (blk_on[0] && program_counter >= block_loop_end_addrs[0]
			&& block_loop_counters[0] != REG_RESET) begin
			next_pc = block_loop_start_addrs[0];
		end
	end

	// Flow state; program counter has no register-port path
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			flow            <= FL_SEQ;
			program_counter <= PC_RESET;
		end else if (fetch_ready) begin
			program_counter <= next_pc;
			unique case (flow)
				FL_SEQ, FL_BLOCK: begin
					if (irq_hit) flow <= FL_IRQ;
					else if (dec_valid && dec_rpt_single) flow <= FL_SINGLE;
					else flow <= (blk_on != 2'b00) ? FL_BLOCK : FL_SEQ;
				end
				FL_SINGLE: begin
					if (irq_hit) flow <= FL_IRQ;
					else if (single_loop_counter == REG_RESET)
						flow <= (blk_on != 2'b00) ? FL_BLOCK : FL_SEQ;
				end
				FL_IRQ: begin
					if (irq_resume) flow <= FL_SEQ;
				end
			endcase
		end
	end

	// Loop counters and block bounds
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			blk_on                     <= 2'b00;
			single_loop_counter        <= REG_RESET;
			computed_single_loop_count <= REG_RESET;
			inner_loop_count_save      <= REG_RESET;
			for (int i = 0; i < 2; i++) begin
				block_loop_counters[i]    <= REG_RESET;
				block_loop_start_addrs[i] <= PC_RESET;
				block_loop_end_addrs[i]   <= PC_RESET;
			end
		end else begin
			if (fetch_ready && dec_valid && dec_rpt_single && flow != FL_SINGLE)
				single_loop_counter <= dec_rpt_count;
			else if (fetch_ready && flow == FL_SINGLE && !irq_hit
				&& single_loop_counter != REG_RESET)
				single_loop_counter <= single_loop_counter - 16'h0001;
			if (fetch_ready && dec_valid && dec_rpt_block) begin
				blk_on[dec_rpt_level]                 <= 1'b1;
				block_loop_start_addrs[dec_rpt_level] <= program_counter + FETCH_STEP;
				block_loop_end_addrs[dec_rpt_level]   <= dec_blk_end;
				block_loop_counters[dec_rpt_level]    <= dec_rpt_count;
				if (dec_rpt_level) inner_loop_count_save <= dec_rpt_count;
			end else if (fetch_ready && !irq_hit) begin
				for (int i = 1; i >= 0; i--) begin
					if (blk_on[i] && program_counter >= block_loop_end_addrs[i]) begin
						if (block_loop_counters[i] == REG_RESET) blk_on[i] <= 1'b0;
						else block_loop_counters[i] <= block_loop_counters[i] - 16'h0001;
					end
				end
			end
			if (reg_wr) begin
				unique case (reg_addr)
					SEL_BLC0:  block_loop_counters[0]    <= reg_wdata;
					SEL_BLC1:  block_loop_counters[1]    <= reg_wdata;
					SEL_BLS1:  inner_loop_count_save     <= reg_wdata;
					SEL_BSA0:  block_loop_start_addrs[0] <= {8'h00, reg_wdata};
					SEL_BSA1:  block_loop_start_addrs[1] <= {8'h00, reg_wdata};
					SEL_BEA0:  block_loop_end_addrs[0]   <= {8'h00, reg_wdata};
					SEL_BEA1:  block_loop_end_addrs[1]   <= {8'h00, reg_wdata};
					SEL_SLC:   single_loop_counter       <= reg_wdata;
					SEL_CSLC:  computed_single_loop_count <= reg_wdata;
					default: ;
				endcase
			end
		end
	end

	// Enable, status and paired context registers
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			return_address_reg   <= 24'h00_0000;
			control_flow_context <= 8'h00;
			irq_taken            <= 1'b0;
			for (int i = 0; i < 2; i++) begin
				irq_enable_regs[i]       <= REG_RESET;
				debug_irq_enable_regs[i] <= REG_RESET;
			end
			for (int i = 0; i < 4; i++) cpu_status_regs[i] <= REG_RESET;
		end else begin
			irq_taken <= fetch_ready && irq_hit && flow != FL_IRQ;
			if (ctx_wr) begin
				{control_flow_context, return_address_reg} <= ctx_wdata;
			end else if (fetch_ready && irq_hit && flow != FL_IRQ) begin
				return_address_reg   <= program_counter;
				control_flow_context <= {4'h0, flow};
			end
			if (reg_wr) begin
				if (reg_addr == SEL_IER0) irq_enable_regs[0] <= reg_wdata;
				if (reg_addr == SEL_IER1) irq_enable_regs[1] <= reg_wdata;
				if (reg_addr == SEL_DIER0) debug_irq_enable_regs[0] <= reg_wdata;
				if (reg_addr == SEL_DIER1) debug_irq_enable_regs[1] <= reg_wdata;
				if (reg_addr >= SEL_ST0 && reg_addr <= SEL_ST3)
					cpu_status_regs[2'(reg_addr - SEL_ST0)] <= reg_wdata;
			end
		end
	end

	// Address ALU result; shifter path overrides result
	always_ff @(posedge ref_clk) begin
		logic [DW-1:0] a;
		logic [DW-1:0] b;
		logic [DW-1:0] r;
		logic [4:0]    ring;
		logic [4:0]    base;
		logic [DW-1:0] off;
		a = areg[alu_dst];
		b = alu_use_imm ? alu_imm : areg[alu_src];
		r = a;
		ring = ring_size_idx(dag_ptr);
		base = ring_base_idx(dag_ptr);
		off  = areg[dag_ptr] + dag_step;
		unique case (alu_op)
			ALU_ADD:  r = a + b;
			ALU_SUB:  r = a - b;
			ALU_CMP:  r = a;
			ALU_AND:  r = a & b;
			ALU_OR:   r = a | b;
			ALU_XOR:  r = a ^ b;
			ALU_SRA:  r = DW'($signed(a) >>> b[3:0]);
			ALU_SRL:  r = a >> b[3:0];
			ALU_SHL:  r = a << b[3:0];
			ALU_ABS:  r = a[DW-1] ? DW'(-a) : a;
			ALU_BTST: r = a;
			ALU_BSET: r = a | (16'h0001 << b[3:0]);
			ALU_BCLR: r = a & ~(16'h0001 << b[3:0]);
			ALU_BNOT: r = a ^ (16'h0001 << b[3:0]);
			ALU_ROL:  r = (a << b[3:0]) | (a >> (5'd16 - {1'b0, b[3:0]}));
			ALU_MOV:  r = b;
		endcase
		if (alu_shifter) r = shifter_val;
		if (sys_rst) begin
			for (int i = 0; i < NAREG; i++) areg[i] <= REG_RESET;
			alu_test_bit <= 1'b0;
		end else begin
			if (alu_go) begin
				alu_test_bit <= (alu_op == ALU_CMP) ? (a == b) : a[b[3:0]];
				if (alu_op != ALU_CMP && alu_op != ALU_BTST) areg[alu_dst] <= r;
			end
			// Post-modify pointer, wrapping inside its ring when circular
			if (dag_go && dag_indirect && !(alu_go && alu_dst == {2'b00, dag_ptr})) begin
				if (dag_circ_req && cpu_status_regs[2][dag_ptr])
					areg[dag_ptr] <= (off >= areg[base] + areg[ring]) ? off - areg[ring] : off;
				else
					areg[dag_ptr] <= off;
			end
			if (reg_wr && reg_addr >= SEL_AREG0)
				areg[5'(reg_addr - SEL_AREG0)] <= reg_wdata;
		end
	end

	// Fetch, data address, loop and parallel-issue outputs
	always_ff @(posedge ref_clk) begin
		logic [DW-1:0] ptr;
		ptr = areg[dag_ptr];
		if (sys_rst) begin
			program_read_address_bus <= PC_RESET;
			prog_fetch_en            <= 1'b0;
			data_addr                <= '0;
			data_rd_en               <= 1'b0;
			data_wr_en               <= 1'b0;
			loop_active              <= 1'b0;
			par_issue                <= 1'b0;
		end else begin
			program_read_address_bus <= next_pc;
			prog_fetch_en            <= fetch_ready;
			loop_active              <= (flow == FL_SINGLE) || (blk_on != 2'b00);
			par_issue                <= dec_valid && dec_data_par
				&& (dec_branch || dec_rpt_single || dec_rpt_block);
			data_rd_en               <= dag_go && !dag_write;
			data_wr_en               <= dag_go && dag_write;
			if (dag_go)
				data_addr <= dag_indirect
					? {areg[16 + 4'd4 + {2'b00, dag_ptr[1:0]} ][6:0], ptr}
					: dag_imm;
		end
	end

	// Read data one cycle after the strobe
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			reg_rdata <= REG_RESET;
			ctx_rdata <= 32'h0000_0000;
		end else begin
			ctx_rdata <= {control_flow_context, return_address_reg};
			reg_rdata <= REG_RESET;
			if (reg_rd) begin
				if (reg_addr >= SEL_AREG0) reg_rdata <= areg[5'(reg_addr - SEL_AREG0)];
				else if (reg_addr <= SEL_BLC1) reg_rdata <= block_loop_counters[reg_addr[0]];
				else if (reg_addr == SEL_BLS1) reg_rdata <= inner_loop_count_save;
				else if (reg_addr <= SEL_BSA1)
					reg_rdata <= block_loop_start_addrs[reg_addr[0] ^ 1'b1][DW-1:0];
				else if (reg_addr <= SEL_BEA1)
					reg_rdata <= block_loop_end_addrs[reg_addr[0] ^ 1'b1][DW-1:0];
				else if (reg_addr == SEL_SLC) reg_rdata <= single_loop_counter;
				else if (reg_addr == SEL_CSLC) reg_rdata <= computed_single_loop_count;
				else if (reg_addr == SEL_IER0 || reg_addr == SEL_IER1)
					reg_rdata <= irq_enable_regs[reg_addr[0] ^ 1'b1];
				else if (reg_addr == SEL_DIER0 || reg_addr == SEL_DIER1)
					reg_rdata <= debug_irq_enable_regs[reg_addr[0] ^ 1'b1];
				else if (reg_addr >= SEL_ST0 && reg_addr <= SEL_ST3)
					reg_rdata <= cpu_status_regs[2'(reg_addr - SEL_ST0)];
			end
		end
	end

	// Assertions
	property p_pab_tracks;
		@(posedge ref_clk) disable iff (sys_rst)
		!sys_rst |=> program_read_address_bus == $past(next_pc);
	endproperty
	a_pab_tracks: assert property (p_pab_tracks) else $error("Fetch bus mismatch");

	property p_seq_step;
		@(posedge ref_clk) disable iff (sys_rst)
		(fetch_ready && flow == FL_SEQ && !irq_hit && !dec_valid && blk_on == 2'b00)
			|=> program_counter == $past(program_counter) + FETCH_STEP;
	endproperty
	a_seq_step: assert property (p_seq_step) else $error("Sequential step wrong");

	property p_irq_enabled;
		@(posedge ref_clk) disable iff (sys_rst)
		irq_taken |-> $past(cpu_status_regs[1][0]);
	endproperty
	a_irq_enabled: assert property (p_irq_enabled) else $error("Irq taken while disabled");

	property p_single_hold;
		@(posedge ref_clk) disable iff (sys_rst)
		(flow == FL_SINGLE && fetch_ready && !irq_hit && !(dec_valid && dec_branch)
			&& single_loop_counter != REG_RESET)
			|=> program_counter == $past(program_counter);
	endproperty
	a_single_hold: assert property (p_single_hold) else $error("Single repeat moved");

	property p_single_end;
		@(posedge ref_clk) disable iff (sys_rst)
		(flow == FL_SINGLE && fetch_ready && !irq_hit && single_loop_counter == REG_RESET)
			|=> flow != FL_SINGLE;
	endproperty
	a_single_end: assert property (p_single_end) else $error("Single loop overran");

	property p_irq_in_loop;
		@(posedge ref_clk) disable iff (sys_rst)
		(flow == FL_SINGLE && fetch_ready && irq_hit) |=> flow == FL_IRQ;
	endproperty
	a_irq_in_loop: assert property (p_irq_in_loop) else $error("Loop not interruptible");

	property p_rd_latency;
		@(posedge ref_clk) disable iff (sys_rst)
		(!reg_rd) |=> reg_rdata == REG_RESET;
	endproperty
	a_rd_latency: assert property (p_rd_latency) else $error("Read data outside slot");

	property p_data_dir;
		@(posedge ref_clk) disable iff (sys_rst)
		dag_go |=> (data_rd_en != data_wr_en) && data_wr_en == $past(dag_write);
	endproperty
	a_data_dir: assert property (p_data_dir) else $error("Data strobe wrong");
endmodule

// ---- dv/pfa_mem_model.sv ----
// Purpose: Memory side stand-in that grants program fetches
// Assumes: Same clock as the core
// Notes:   Slow mode grants every other cycle to stretch fetches
module pfa_mem_model (
	// Clock and reset
	input  wire logic ref_clk,
	input  wire logic sys_rst,
	// Fetch handshake
	input  wire logic slow,
	output logic      fetch_ready
);
	timeunit 1ns;
	timeprecision 1ps;
	// Low in reset so no fetch is granted before release
	always_ff @(posedge ref_clk) begin
		if (sys_rst)
			fetch_ready <= 1'b0;
		else if (slow)
			fetch_ready <= ~fetch_ready;
		else
			fetch_ready <= 1'b1;
	end
endmodule

// ---- dv/test_pfa_core.sv ----
// Purpose: Self-checking bench for the program flow and address core
// Assumes: Prompt memory unless a scenario asks for stalls
// Notes:   Loop and branch timing judged inside bounded windows
module test_pfa_core
	import pfa_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic ref_clk, sys_rst, dec_valid, dec_branch, dec_branch_reg, dec_cond, dec_rpt_single;
	logic dec_rpt_block, dec_rpt_level, dec_data_par, fetch_ready, irq_resume, ctx_wr, reg_wr;
	logic reg_rd, alu_go, alu_use_imm, alu_shifter, dag_go, dag_indirect, dag_circ_req;
	logic dag_write, prog_fetch_en, data_rd_en, data_wr_en, irq_taken, alu_test_bit;
	logic loop_active, par_issue, slow;
	logic [3:0]     dec_cond_sel;
	logic [7:0]     test_flags;
	logic [5:0]     reg_addr;
	logic [4:0]     alu_dst, alu_src;
	logic [2:0]     dag_ptr;
	logic [PAW-1:0] dec_imm_addr, dec_blk_end, dcu_reg_addr, program_read_address_bus, watch;
	logic [DW-1:0]  dec_rpt_count, reg_wdata, alu_imm, shifter_val, dag_step, reg_rdata;
	logic [DAW-1:0] dag_imm, data_addr;
	logic [31:0]    irq_req, dbg_irq_req, ctx_wdata, ctx_rdata;
	pfa_alu_op_t    alu_op;
	int             err_total, check_count, hits, pars, irqs;

	pfa_core dut (.*);
	pfa_mem_model mem (.*);

	always #10 ref_clk = ~ref_clk;
	// Event counters sampled at the edge, before the core updates
	always @(posedge ref_clk) begin
		hits += (program_read_address_bus === watch);
		pars += (par_issue === 1'b1);
		irqs += (irq_taken === 1'b1);
	end

	task automatic chk(input logic [31:0] e, input logic [31:0] g);
		check_count++;
		if (e !== g) begin
			err_total++;
			$display("ERROR t=%0t exp=%h got=%h", $time, e, g);
		end
	endtask
	task automatic give_verdict();
		$display("checks=%0d errors=%0d", check_count, err_total);
		if (err_total == 0 && check_count > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge ref_clk);
	endtask
	task automatic rst();
		@(posedge ref_clk);
		sys_rst <= 1'b1;
		tick(20);
		sys_rst <= 1'b0;
	endtask
	task automatic wr(input logic [5:0] a, input logic [DW-1:0] d);
		@(posedge ref_clk);
		{reg_wr, reg_addr, reg_wdata} <= {1'b1, a, d};
		@(posedge ref_clk);
		reg_wr <= 1'b0;
	endtask
	task automatic rd(input logic [5:0] a, output logic [DW-1:0] d);
		@(posedge ref_clk);
		{reg_rd, reg_addr} <= {1'b1, a};
		@(posedge ref_clk);
		reg_rd <= 1'b0;
		#1 d = reg_rdata;
	endtask
	// Valid held until an edge where memory grants the fetch
	task automatic issue();
		@(posedge ref_clk);
		dec_valid <= 1'b1;
		do @(posedge ref_clk); while (fetch_ready !== 1'b1);
		dec_valid <= 1'b0;
		{dec_branch, dec_branch_reg, dec_cond, dec_rpt_single, dec_rpt_block, dec_data_par} <= '0;
	endtask
	task automatic seq_ok();
		logic [PAW-1:0] a;
		#1 a = program_read_address_bus;
		tick(4);
		#1 chk(32'(4 * FETCH_STEP), 32'(program_read_address_bus - a));
		chk(0, loop_active);
		chk(1, prog_fetch_en);
	endtask

	task automatic s_regs();
		logic [DW-1:0] d;
		for (int i = 0; i < 18; i++) begin
			rd(6'(i), d);
			chk(REG_RESET, d);
			wr(6'(i), 16'hA500 + 16'(i));
			rd(6'(i), d);
			chk(i < 17 ? 16'hA500 + 16'(i) : REG_RESET, d);
		end
		@(posedge ref_clk);
		{ctx_wr, ctx_wdata} <= {1'b1, 32'h5A12_3456};
		@(posedge ref_clk);
		ctx_wr <= 1'b0;
		tick(1);
		#1 chk(32'h5A12_3456, ctx_rdata);
	endtask
	task automatic s_fetch(input logic s, input int exp);
		logic [PAW-1:0] a;
		@(posedge ref_clk);
		slow <= s;
		tick(4);
		#1 a = program_read_address_bus;
		tick(8);
		#1 chk(exp, 32'(program_read_address_bus - a));
	endtask
	task automatic s_branch(input logic [PAW-1:0] t, input logic [2:0] m,
		input logic [3:0] sel, input int exp);
		@(posedge ref_clk);
		{dec_data_par, dec_cond, dec_branch_reg, dec_branch} <= {m, 1'b1};
		dec_imm_addr <= m[0] ? ~t : t;
		dcu_reg_addr <= t;
		dec_cond_sel <= sel;
		watch = t;
		issue();
		#1 hits = 0;
		pars = 0;
		tick(10);
		chk(exp, hits != 0);
		chk(m[2], pars != 0);
	endtask
	task automatic s_single();
		@(posedge ref_clk);
		{dec_rpt_single, dec_rpt_count} <= {1'b1, 16'h0005};
		issue();
		#1 watch = program_read_address_bus;
		hits = 0;
		tick(20);
		chk(32'd6, hits);
		seq_ok();
	endtask
	task automatic s_block();
		for (int lv = 0; lv < 2; lv++) begin
			@(posedge ref_clk);
			watch = program_read_address_bus + 24'h00_0018;
			{dec_rpt_block, dec_rpt_level, dec_rpt_count} <= {1'b1, lv[0], 16'h0002};
			dec_blk_end <= watch;
			issue();
			#1 hits = 0;
			tick(40);
			chk(3, hits);
			seq_ok();
		end
	endtask
	task automatic s_irq();
		@(posedge ref_clk);
		{dec_rpt_single, dec_rpt_count} <= {1'b1, 16'h0064};
		issue();
		irq_req <= 32'h0000_0008;
		wr(SEL_ST0 + 6'h01, 16'h0001);
		#1 irqs = 0;
		tick(8);
		chk(0, irqs);
		chk(1, loop_active);
		#1 watch = IRQ_BASE + 24'(3 * int'(IRQ_VECTOR_STRIDE));
		hits = 0;
		wr(SEL_IER0, 16'h0008);
		tick(10);
		chk(1, irqs);
		chk(1, hits != 0);
		{irq_req, irq_resume} <= {32'h0000_0000, 1'b1};
		@(posedge ref_clk);
		irq_resume <= 1'b0;
	endtask
	task automatic dag(input logic ind, input logic circ, input logic w, input logic [DAW-1:0] im);
		@(posedge ref_clk);
		{dag_go, dag_indirect, dag_circ_req, dag_write, dag_imm} <= {1'b1, ind, circ, w, im};
		@(posedge ref_clk);
		dag_go <= 1'b0;
		#1;
	endtask
	task automatic s_dag();
		logic [DW-1:0] d;
		dag(0, 0, 0, 23'h7F_FFFF);
		chk(23'h7F_FFFF, data_addr);
		chk(1, data_rd_en);
		dag(0, 0, 1, 23'h00_1234);
		chk(1, data_wr_en);
		wr(SEL_AREG0 + 6'h09, 16'h0004);
		wr(SEL_ST0 + 6'h02, 16'h0004);
		for (int c = 0; c < 2; c++) begin
			wr(SEL_AREG0 + 6'h02, 16'h0003);
			dag(1, c[0], 0, 23'h00_0000);
			rd(SEL_AREG0 + 6'h02, d);
			chk(c ? 16'h0002 : 16'h0006, d);
		end
	endtask
	task automatic alu(input pfa_alu_op_t op, input logic sh);
		@(posedge ref_clk);
		{alu_go, alu_shifter, alu_use_imm} <= {1'b1, sh, op != ALU_ABS};
		alu_op <= op;
		@(posedge ref_clk);
		alu_go <= 1'b0;
	endtask
	task automatic s_alu();
		pfa_alu_op_t ops[15] = '{ALU_ADD, ALU_SUB, ALU_AND, ALU_OR, ALU_XOR, ALU_SRA, ALU_SRL,
			ALU_SHL, ALU_ABS, ALU_BSET, ALU_BCLR, ALU_BNOT, ALU_ROL, ALU_MOV, ALU_MOV};
		logic [DW-1:0] ex[15] = '{16'h8424, 16'h8422, 16'h0001, 16'h8423, 16'h8422, 16'hC211,
			16'h4211, 16'h0846, 16'h7BDD, 16'h8423, 16'h8421, 16'h8421, 16'h0847, 16'h0001, 16'hBEEF};
		logic [DW-1:0] d;
		for (int i = 0; i < 15; i++) begin
			wr(6'h30, 16'h8423);
			alu(ops[i], i == 14);
			rd(6'h30, d);
			chk(ex[i], d);
		end
		alu(ALU_BTST, 1'b0);
		#1 chk(1, alu_test_bit);
		alu(ALU_CMP, 1'b0);
		#1 chk(0, alu_test_bit);
		rd(6'h30, d);
		chk(16'hBEEF, d);
	endtask

	initial begin
		{ref_clk, sys_rst, slow, err_total, check_count, hits, pars, irqs} = {3'b010, 160'h0};
		{dec_valid, dec_branch, dec_branch_reg, dec_cond, dec_cond_sel, dec_imm_addr} = '0;
		{dec_rpt_single, dec_rpt_block, dec_rpt_level, dec_rpt_count, dec_blk_end} = '0;
		{dec_data_par, dcu_reg_addr, test_flags, irq_req, dbg_irq_req, irq_resume} = '0;
		{ctx_wr, ctx_wdata, reg_addr, reg_wdata, reg_wr, reg_rd, alu_go, alu_dst} = '0;
		{alu_src, alu_imm, alu_use_imm, alu_shifter, shifter_val, dag_go, dag_indirect} = '0;
		{dag_circ_req, dag_ptr, dag_step, dag_imm, dag_write, watch} = '0;
		alu_op = ALU_ADD;
		tick(20);
		sys_rst <= 1'b0;
		{alu_dst, alu_src, alu_imm, shifter_val} <= {5'h10, 5'h10, 16'h0001, 16'hBEEF};
		{test_flags, dag_ptr, dag_step} <= {8'h04, 3'h2, 16'h0003};
		s_regs();
		rst();
		s_fetch(1, 16);
		s_fetch(0, 32);
		s_branch(24'h01_2340, 3'b100, 4'h0, 1);
		s_branch(24'h03_5670, 3'b001, 4'h0, 1);
		s_branch(24'h05_0000, 3'b010, 4'h2, 1);
		s_branch(24'h07_0000, 3'b010, 4'hA, 0);
		s_branch(24'h09_0000, 3'b010, 4'h3, 0);
		s_single();
		s_block();
		rst();
		s_irq();
		rst();
		s_dag();
		s_alu();
		give_verdict();
	end
	// Whole run is about 550 cycles; this leaves a wide margin
	initial begin
		#200_000;
		err_total++;
		give_verdict();
	end
endmodule
